// file: core/lcc_ctrl.sv
// Cache control: register slave, invalidation sweep, test modes, bursts
//
// Local design decisions: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
module lcc_ctrl
  import lcc_pkg::*;
#(
  parameter logic [14:0] INV_LAST = LCC_TAG_LAST
) (
  input  wire logic        sys_clk_in,
  input  wire logic        rstn_in,
  input  wire logic        hsel_in,
  input  wire logic [31:0] haddr_in,
  input  wire logic [1:0]  htrans_in,
  input  wire logic        hwrite_in,
  input  wire logic [2:0]  hsize_in,
  input  wire logic [31:0] hwdata_in,
  input  wire logic        hready_in,
  output logic             hreadyout_out,
  output logic             hresp_out,
  output logic [31:0]      hrdata_out,
  input  wire logic        req_valid_in,
  input  wire logic [1:0]  req_op_in,
  input  wire logic        req_write_in,
  input  wire logic [31:0] req_addr_in,
  input  wire logic [3:0]  storage_attribute_bits_in,
  input  wire logic        xlate_in,
  input  wire logic        l1d_off_in,
  input  wire logic        tag_hit_in,
  output logic             req_ready_out,
  output logic             tag_clr_out,
  output logic [14:0]      tag_idx_out,
  output logic             tag_alloc_out,
  output logic             sram_en_out,
  output logic             sram_we_out,
  output logic [16:0]      sram_addr_out,
  output logic [1:0]       sram_type_out,
  output logic             sram_clk_out,
  output logic             bus_issue_out,
  output logic             broadcast_out,
  output logic             hit_ev_out,
  output logic             miss_ev_out
);
  typedef struct packed {
    logic [18:0] cfg;
    lcc_inv_type inv_st;
    logic [14:0] idx;
    logic        tag_clr;
    logic        hready;
    logic [31:0] rdata;
    logic        wr_pend;
    logic        wr_ctrl;
    logic        burst;
    logic [1:0]  beat;
    logic        bwrite;
    logic [16:0] base;
    logic        sram_en;
    logic        sram_we;
    logic [16:0] sram_addr;
    logic        alloc;
    logic        bus_issue;
    logic        broadcast;
    logic        hit_ev;
    logic        miss_ev;
    logic        ready;
  } lcc_core_type;

  lcc_core_type st;
  lcc_core_type next_st;
  lcc_clk_if    clk_if ();

  logic       ip;
  logic       live;
  logic       cach;
  logic       take;
  logic       excl;
  logic       push;
  lcc_op_type op;

  lcc_clk_dll u_dll (
    .sys_clk_in (sys_clk_in),
    .rstn_in    (rstn_in),
    .clk_if     (clk_if.dll_side)
  );

  assign clk_if.ratio = st.cfg[LCC_CLK_LO +: 3];
  // flag set from the start request on
  // Early poll after the write must not read a finished sweep
  assign ip   = (st.inv_st == LCC_INV_SWEEP)
              || (st.inv_st == LCC_INV_IDLE && st.cfg[LCC_BIT_INV]);
  // only the cache is held off during a sweep
  assign live = st.cfg[LCC_BIT_EN] && !ip;
  assign excl = st.cfg[LCC_BIT_EXCL];
  assign push = st.cfg[LCC_BIT_PUSH];
  assign take = req_valid_in && st.ready;
  assign op   = lcc_op_type'(req_op_in);
  assign cach = xlate_in ? (!storage_attribute_bits_in[LCC_STORAGE_ATTRIBUTE_BITS_I] && l1d_off_in)
                         : (storage_attribute_bits_in == LCC_STORAGE_ATTRIBUTE_BITS_DFLT);

  always_comb begin
    next_st = st;
    next_st.hready = 1'b1;
    next_st.wr_pend = 1'b0;
    next_st.tag_clr = 1'b0;
    next_st.sram_en = 1'b0;
    next_st.sram_we = 1'b0;
    next_st.alloc = 1'b0;
    next_st.bus_issue = 1'b0;
    next_st.broadcast = 1'b0;
    next_st.hit_ev = 1'b0;
    next_st.miss_ev = 1'b0;

    // Register slave, zero wait states
    if (st.wr_pend) begin
      if (st.wr_ctrl) begin
        next_st.cfg = hwdata_in[LCC_CFG_W-1:0];
        if (hwdata_in[LCC_RAM_LO +: 2] == LCC_RAM_RSVD) begin
          next_st.cfg[LCC_RAM_LO +: 2] = st.cfg[LCC_RAM_LO +: 2];
        end
      end
    end
    if (hsel_in && hready_in && htrans_in == LCC_HTRANS_NSQ) begin
      next_st.wr_pend = hwrite_in;
      next_st.wr_ctrl = (haddr_in[11:0] == LCC_OFS_CTRL);
      case (haddr_in[11:0])
        LCC_OFS_CTRL: next_st.rdata = {ip, 12'h000, st.cfg};
        LCC_OFS_STAT: next_st.rdata = {31'h0000_0000, clk_if.locked};
        default:      next_st.rdata = 32'h0000_0000;
      endcase
    end

    case (st.inv_st)
      LCC_INV_IDLE: begin
        if (st.cfg[LCC_BIT_INV]) begin
          next_st.inv_st = LCC_INV_SWEEP;
          next_st.idx = 15'h0000;
        end
      end
      LCC_INV_SWEEP: begin
        // zero entry incl. status and LRU
        // Index steps only after its own clear pulse, so entry zero is hit
        next_st.tag_clr = 1'b1;
        if (st.tag_clr) begin
          next_st.idx = 15'(st.idx + 15'h0001);
        end
        if (st.tag_clr && st.idx == INV_LAST) begin
          next_st.inv_st = LCC_INV_DONE;
          next_st.tag_clr = 1'b0;
          next_st.idx = st.idx;
        end
      end
      LCC_INV_DONE: begin
        // rearm only after the bit is cleared
        if (!st.cfg[LCC_BIT_INV]) begin
          next_st.inv_st = LCC_INV_IDLE;
        end
      end
      default: next_st.inv_st = LCC_INV_IDLE;
    endcase

    if (st.burst && clk_if.tick) begin
      next_st.sram_en = 1'b1;
      next_st.sram_we = st.bwrite;
      next_st.sram_addr = {st.base[16:2], st.beat};
      next_st.beat = 2'(st.beat + 2'h1);
      if (st.beat == LCC_BEAT_LAST) begin
        next_st.burst = 1'b0;
      end
    end

    if (take) begin
      case (op)
        LCC_OP_SINGLE: begin
          if (live && cach) begin
            next_st.hit_ev = tag_hit_in;
            next_st.miss_ev = !tag_hit_in;
            if (tag_hit_in) begin
              next_st.sram_en = 1'b1;
              next_st.sram_we = req_write_in;
              next_st.sram_addr = req_addr_in[19:3];
              next_st.bus_issue = req_write_in && !push;
            end else begin
              // drop write miss in test push
              next_st.bus_issue = !(req_write_in && push);
            end
          end else begin
            next_st.bus_issue = 1'b1;
          end
        end
        LCC_OP_FETCH: begin
          next_st.bus_issue = !(live && tag_hit_in);
          if (live) begin
            next_st.hit_ev = tag_hit_in;
            next_st.miss_ev = !tag_hit_in;
          end
          if (live && !tag_hit_in && !excl) begin
            next_st.alloc = 1'b1;
            next_st.burst = 1'b1;
            next_st.bwrite = 1'b1;
          end else if (live && tag_hit_in) begin
            next_st.burst = 1'b1;
            next_st.bwrite = 1'b0;
          end
          next_st.beat = 2'h0;
          next_st.base = req_addr_in[19:3];
        end
        LCC_OP_PUSH: begin
          // pushed block written into the cache in test push, else sent to the bus
          if (live && push) begin
            next_st.alloc = 1'b1;
            next_st.burst = 1'b1;
            next_st.bwrite = 1'b1;
          end else begin
            next_st.bus_issue = 1'b1;
          end
          next_st.beat = 2'h0;
          next_st.base = req_addr_in[19:3];
        end
        LCC_OP_ZERO: begin
          // quiet block zero in test push
          next_st.broadcast = !push;
        end
        default: next_st.bus_issue = 1'b1;
      endcase
    end
    next_st.ready = !next_st.burst;
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      st <= '0;
      st.cfg <= LCC_CFG_RST;
      st.hready <= 1'b1;
      st.ready <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign hreadyout_out = st.hready;
  assign hresp_out     = 1'b0;
  assign hrdata_out    = st.rdata;
  assign req_ready_out = st.ready;
  assign tag_clr_out   = st.tag_clr;
  assign tag_idx_out   = st.idx;
  assign tag_alloc_out = st.alloc;
  assign sram_en_out   = st.sram_en;
  assign sram_we_out   = st.sram_we;
  assign sram_addr_out = st.sram_addr;
  assign sram_type_out = st.cfg[LCC_RAM_LO +: 2];
  assign sram_clk_out  = clk_if.tick;
  assign bus_issue_out = st.bus_issue;
  assign broadcast_out = st.broadcast;
  assign hit_ev_out    = st.hit_ev;
  assign miss_ev_out   = st.miss_ev;

  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rstn_in);

  sequence s_arm;
    st.inv_st == LCC_INV_IDLE && st.cfg[LCC_BIT_INV];
  endsequence
  sequence s_first_clear;
    tag_clr_out && tag_idx_out == 15'h0000;
  endsequence

  a_inv_start : assert property (s_arm |=> ip ##1 s_first_clear)
    else $error("Sweep did not start at entry zero");

  a_sweep_step : assert property (
    tag_clr_out && $past(tag_clr_out) |->
      tag_idx_out == 15'($past(tag_idx_out) + 15'h0001))
    else $error("Sweep skipped an entry");

  a_ip_done : assert property (
    tag_clr_out && tag_idx_out == INV_LAST |=> !ip && !tag_clr_out)
    else $error("Flag stayed set after last entry");

  a_no_restart : assert property (
    st.inv_st == LCC_INV_DONE && st.cfg[LCC_BIT_INV] |=> !ip)
    else $error("Sweep restarted without clearing bit");

  a_excl_fetch : assert property (
    take && op == LCC_OP_FETCH && excl |=> !tag_alloc_out)
    else $error("Excluded fetch allocated a line");

  a_push_drop : assert property (
    take && op == LCC_OP_SINGLE && live && cach && req_write_in
      && !tag_hit_in && push |=> !bus_issue_out && miss_ev_out)
    else $error("Test push write miss reached bus");

  a_zero_quiet : assert property (
    take && op == LCC_OP_ZERO |=> broadcast_out == !$past(push))
    else $error("Block zero broadcast wrong");

  a_hit_serve : assert property (
    take && op == LCC_OP_SINGLE && live && cach && tag_hit_in
      |=> hit_ev_out && sram_en_out && !miss_ev_out)
    else $error("Single-beat hit not served");

  a_reset_off : assert property (@(posedge sys_clk_in) disable iff (1'b0)
    !rstn_in |=> !st.cfg[LCC_BIT_EN] && !clk_if.locked)
    else $error("Cache or DLL on after reset");
endmodule

// file: core/lcc_pkg.sv
// Package: register map, field layout and timing for the cache control block
package lcc_pkg;
  localparam logic [11:0] LCC_OFS_CTRL   = 12'h000;
  localparam logic [11:0] LCC_OFS_STAT   = 12'h004;
  localparam int          LCC_BIT_EN     = 0;
  localparam int          LCC_CLK_LO     = 4;
  localparam int          LCC_RAM_LO     = 7;
  localparam int          LCC_BIT_EXCL   = 9;
  localparam int          LCC_BIT_INV    = 10;
  localparam int          LCC_BIT_PUSH   = 13;
  localparam int          LCC_BIT_IP     = 31;
  localparam int          LCC_CFG_W      = 19;
  localparam logic [18:0] LCC_CFG_RST    = 19'h0_0000;
  localparam logic [1:0]  LCC_RAM_RSVD   = 2'h1;
  localparam logic [3:0]  LCC_STORAGE_ATTRIBUTE_BITS_DFLT  = 4'h3;
  localparam int          LCC_STORAGE_ATTRIBUTE_BITS_I     = 2;
  localparam logic [14:0] LCC_TAG_LAST   = 15'h7fff;
  localparam logic [9:0]  LCC_DLL_LOCK   = 10'h280;
  localparam logic [1:0]  LCC_BEAT_LAST  = 2'h3;
  localparam logic [1:0]  LCC_HTRANS_NSQ = 2'h2;
  localparam logic [2:0]  LCC_CLK_OFF    = 3'h0;

  typedef enum logic [1:0] {
    LCC_OP_SINGLE = 2'b00,
    LCC_OP_FETCH  = 2'b01,
    LCC_OP_PUSH   = 2'b10,
    LCC_OP_ZERO   = 2'b11
  } lcc_op_type;

  typedef enum logic [1:0] {
    LCC_INV_IDLE  = 2'b00,
    LCC_INV_SWEEP = 2'b01,
    LCC_INV_DONE  = 2'b10
  } lcc_inv_type;

  // SRAM period in half core cycles for a ratio code
  function automatic logic [3:0] lcc_halves(input logic [2:0] ratio);
    case (ratio)
      3'h1:    lcc_halves = 4'h2;
      3'h2:    lcc_halves = 4'h3;
      3'h3:    lcc_halves = 4'h4;
      3'h4:    lcc_halves = 4'h5;
      3'h5:    lcc_halves = 4'h6;
      default: lcc_halves = 4'h0;
    endcase
  endfunction
endpackage

// file: core/lcc_clk_if.sv
// Interface: clock ratio, SRAM tick and DLL lock between core and divider
`timescale 1ns/1ps
interface lcc_clk_if;
  logic [2:0] ratio;
  logic       tick;
  logic       locked;
  modport core_side (output ratio, input tick, input locked);
  modport dll_side  (input ratio, output tick, output locked);
endinterface

// file: core/lcc_clk_dll.sv
// SRAM clock divider and DLL lock timer
`timescale 1ns/1ps
module lcc_clk_dll
  import lcc_pkg::*;
(
  input  wire logic   sys_clk_in,
  input  wire logic   rstn_in,
  lcc_clk_if.dll_side clk_if
);
  typedef struct packed {
    logic [2:0] ratio;
    logic [3:0] acc;
    logic       tick;
    logic [9:0] cnt;
    logic       locked;
  } lcc_dll_type;

  lcc_dll_type st;
  lcc_dll_type next_st;

  always_comb begin
    next_st = st;
    next_st.tick = 1'b0;
    next_st.ratio = clk_if.ratio;
    if (clk_if.ratio != st.ratio || clk_if.ratio == LCC_CLK_OFF) begin
      // Ratio change relocks; zero ratio keeps DLL off
      next_st.acc = 4'h0;
      next_st.cnt = 10'h000;
      next_st.locked = 1'b0;
    end else begin
      // fractional divide
      // Two half cycles per core edge, one tick per SRAM period
      if (st.acc + 4'h2 >= lcc_halves(st.ratio)) begin
        next_st.acc = 4'(st.acc + 4'h2 - lcc_halves(st.ratio));
        next_st.tick = 1'b1;
      end else begin
        next_st.acc = 4'(st.acc + 4'h2);
      end
      // alignment done well inside one sweep
      if (st.tick && !st.locked) begin
        next_st.cnt = 10'(st.cnt + 10'h001);
        next_st.locked = (st.cnt + 10'h001 == LCC_DLL_LOCK);
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign clk_if.tick   = st.tick;
  assign clk_if.locked = st.locked;

  a_dll_off : assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    clk_if.ratio == LCC_CLK_OFF |=> !clk_if.locked)
    else $error("DLL locked with ratio zero");
endmodule

// file: verification/lcc_sram_model.sv
// Far-side tag store that answers lookups and follows clears and fills
`timescale 1ns/1ps
module lcc_sram_model (
  input  wire logic        sys_clk_in,
  input  wire logic        take_in,
  input  wire logic [31:0] addr_in,
  input  wire logic        clr_in,
  input  wire logic [14:0] idx_in,
  input  wire logic        alloc_in,
  output logic             hit_out
);
  logic        valid [0:32767];
  logic [14:0] line;
  assign hit_out = valid[addr_in[19:5]];
  always @(posedge sys_clk_in) begin
    if (take_in) begin
      line <= addr_in[19:5];
    end
    if (clr_in) begin
      valid[idx_in] <= 1'b0;
    end
    if (alloc_in) begin
      valid[line] <= 1'b1;
    end
  end
  // Power-up garbage: every entry looks valid until swept
  initial foreach (valid[i]) valid[i] = 1'b1;
endmodule

// file: verification/test_l2_cache_invalidate_test_ctrl.sv
// Self-checking bench for the cache control block
`timescale 1ns/1ps
module test_l2_cache_invalidate_test_ctrl;
  import lcc_pkg::*;
  logic        clk, rstn, hsel, hwrite, hready, hresp;
  logic        rq_v, rq_w, xlate, l1off, hit, rdy;
  logic        clr, alloc, en, we, tick, bus, bc, hev, mev;
  logic [31:0] haddr, hwdata, hrdata, rq_a, r;
  logic [1:0]  htrans, rq_op, stype;
  logic [3:0]  storage_attribute_bits;
  logic [14:0] idx;
  logic [16:0] sa;
  logic [16:0] beats[$];
  int          errors, samples_checked, cyc;
  int          n[9];
  wire  [8:0]  evs = {tick, clr, we, en, alloc, bc, bus, mev, hev};

  lcc_ctrl #(.INV_LAST(15'h003f)) lcc_ctrl_i (
    .sys_clk_in(clk), .rstn_in(rstn), .hsel_in(hsel), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2),
    .hwdata_in(hwdata), .hready_in(hready), .hreadyout_out(hready),
    .hresp_out(hresp), .hrdata_out(hrdata), .req_valid_in(rq_v),
    .req_op_in(rq_op), .req_write_in(rq_w), .req_addr_in(rq_a),
    .storage_attribute_bits_in(storage_attribute_bits), .xlate_in(xlate), .l1d_off_in(l1off),
    .tag_hit_in(hit), .req_ready_out(rdy), .tag_clr_out(clr),
    .tag_idx_out(idx), .tag_alloc_out(alloc), .sram_en_out(en),
    .sram_we_out(we), .sram_addr_out(sa), .sram_type_out(stype),
    .sram_clk_out(tick), .bus_issue_out(bus), .broadcast_out(bc),
    .hit_ev_out(hev), .miss_ev_out(mev));

  lcc_sram_model lcc_sram_model_i (
    .sys_clk_in(clk), .take_in(rq_v && rdy), .addr_in(rq_a),
    .clr_in(clr), .idx_in(idx), .alloc_in(alloc), .hit_out(hit));

  task automatic chk(input string s, input logic [31:0] e,
                     input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", s, e, g);
      errors++;
    end
  endtask

  // Event counters and sweep order, sampled mid-cycle where settled
  always @(negedge clk) begin
    cyc++;
    if (clr === 1'b1) begin
      chk("sweep index", 32'(n[7] % 64), {17'h0_0000, idx});
    end
    for (int i = 0; i < 9; i++) n[i] += int'(evs[i] === 1'b1);
    if (en === 1'b1) begin
      beats.push_back(sa);
    end
  end

  task automatic ahb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= {20'h0_0000, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    q = hrdata;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    ahb(1'b1, a, d, r);
  endtask

  task automatic rdc(input string s, input logic [11:0] a,
                     input logic [31:0] e);
    ahb(1'b0, a, 32'h0000_0000, r);
    chk(s, e, r);
  endtask

  task automatic poll();
    do ahb(1'b0, 12'h000, 32'h0000_0000, r); while (r[31] === 1'b1);
    chk("sweep finished", 32'h0000_0410, r);
  endtask

  task automatic req(input logic [1:0] op, input logic w,
                     input logic [31:0] a);
    for (int i = 0; i < 7; i++) n[i] = 0;
    beats.delete();
    rq_v <= 1'b1;
    rq_op <= op;
    rq_w <= w;
    rq_a <= a;
    do @(posedge clk); while (rdy !== 1'b1);
    rq_v <= 1'b0;
    repeat (2) @(posedge clk);
    while (rdy !== 1'b1) @(posedge clk);
    @(posedge clk);
  endtask

  // Nibbles: hit miss bus broadcast alloc beats writes
  task automatic ev(input logic [27:0] m, input logic [27:0] e);
    logic [27:0] g;
    g = {n[0][3:0], n[1][3:0], n[2][3:0], n[3][3:0], n[4][3:0],
         n[5][3:0], n[6][3:0]};
    chk("events", {4'h0, e}, {4'h0, g & m});
  endtask

  task automatic t_reset();
    rdc("control", 12'h000, 32'h0000_0000);
    rdc("status", 12'h004, 32'h0000_0000);
    rdc("unmapped", 12'h008, 32'h0000_0000);
    chk("response", 32'h0000_0000, {31'h0, hresp});
    $display("test reset done");
  endtask

  task automatic t_regs();
    logic [1:0] t[3] = '{2'h0, 2'h2, 2'h3};
    wr(12'h000, 32'hfff7_fbfe);
    rdc("control", 12'h000, 32'h0007_fbfe);
    wr(12'h000, 32'h0000_0080);
    rdc("reserved type", 12'h000, 32'h0000_0180);
    wr(12'h008, 32'hffff_ffff);
    rdc("unmapped", 12'h008, 32'h0000_0000);
    foreach (t[i]) begin
      wr(12'h000, {23'h00_0000, t[i], 7'h00});
      @(posedge clk);
      chk("ram type", {30'h0, t[i]}, {30'h0, stype});
    end
    $display("test registers done");
  endtask

  task automatic t_clock();
    int e[5] = '{120, 80, 60, 48, 40};
    int g;
    for (int k = 1; k < 6; k++) begin
      wr(12'h000, 32'(k) << 4);
      n[8] = 0;
      repeat (120) @(posedge clk);
      g = (n[8] >= e[k-1] - 2 && n[8] <= e[k-1] + 2) ? e[k-1] : n[8];
      chk("tick count", 32'(e[k-1]), 32'(g));
    end
    wr(12'h000, 32'h0000_0010);
    n[8] = 0;
    while (n[8] < 620) @(posedge clk);
    rdc("lock early", 12'h004, 32'h0000_0000);
    while (n[8] < 660) @(posedge clk);
    rdc("lock", 12'h004, 32'h0000_0001);
    $display("test clock done");
  endtask

  task automatic t_sweep();
    n[7] = 0;
    wr(12'h000, 32'h0000_0410);
    rdc("in progress", 12'h000, 32'h8000_0410);
    req(2'h0, 1'b0, 32'h0000_0100);
    ev(28'hf0f_0000, 28'h001_0000);
    poll();
    chk("entries", 32'h0000_0040, 32'(n[7]));
    repeat (20) @(posedge clk);
    rdc("no restart", 12'h000, 32'h0000_0410);
    wr(12'h000, 32'h0000_0010);
    wr(12'h000, 32'h0000_0410);
    rdc("restart", 12'h000, 32'h8000_0410);
    poll();
    chk("entries", 32'h0000_0080, 32'(n[7]));
    wr(12'h000, 32'h0000_0010);
    $display("test sweep done");
  endtask

  task automatic t_ops();
    wr(12'h000, 32'h0000_0111);
    req(2'h1, 1'b0, 32'h0000_0100);
    ev(28'hfff_ffff, 28'h011_0144);
    foreach (beats[i]) chk("beat", 32'h20 + i, {15'h0, beats[i]});
    req(2'h0, 1'b0, 32'h0000_0100);
    ev(28'hfff_ff00, 28'h100_0000);
    req(2'h0, 1'b1, 32'h0000_0100);
    ev(28'hfff_ff00, 28'h101_0000);
    xlate <= 1'b1;
    storage_attribute_bits <= 4'h0;
    l1off <= 1'b1;
    req(2'h0, 1'b0, 32'h0000_0100);
    ev(28'hf00_0000, 28'h100_0000);
    l1off <= 1'b0;
    req(2'h0, 1'b0, 32'h0000_0100);
    ev(28'hf00_0000, 28'h000_0000);
    xlate <= 1'b0;
    storage_attribute_bits <= 4'h3;
    wr(12'h000, 32'h0000_0311);
    req(2'h1, 1'b0, 32'h0000_0200);
    ev(28'h000_0ff0, 28'h000_0000);
    req(2'h0, 1'b0, 32'h0000_0200);
    ev(28'hff0_0000, 28'h010_0000);
    wr(12'h000, 32'h0000_2111);
    req(2'h0, 1'b1, 32'h0000_0300);
    ev(28'h0ff_0000, 28'h010_0000);
    req(2'h3, 1'b0, 32'h0000_0300);
    ev(28'h000_f000, 28'h000_0000);
    req(2'h2, 1'b0, 32'h0000_0400);
    ev(28'h00f_000f, 28'h000_0004);
    wr(12'h000, 32'h0000_0111);
    req(2'h3, 1'b0, 32'h0000_0300);
    ev(28'h000_f000, 28'h000_1000);
    $display("test requests done");
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  initial begin
    repeat (12000) @(posedge clk);
    errors++;
    print_verdict();
  end

  initial begin
    {rstn, hsel, hwrite, rq_v, rq_w, xlate, l1off} = 7'h00;
    {haddr, hwdata, rq_a} = 96'h0;
    {htrans, rq_op} = 4'h0;
    storage_attribute_bits = 4'h3;
    errors = 0;
    samples_checked = 0;
    cyc = 0;
    n = '{default: 0};
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    t_reset();
    t_regs();
    t_clock();
    t_sweep();
    t_ops();
    print_verdict();
  end
endmodule
